//--- verilog/clrc_ctrl.sv
// Control and status logic for three comparators and a 32-level ladder
//
// Function
// - Enabled comparator and interrupt keep running asleep
// - Comparator setups unchanged by sleep and wake
// - Reset clears comparator setups, all off
// - Five-bit ladder code selects 32 levels
// - Level is low rail plus code/32 span
// - Ladder bit 7 powers reference
// - Ladder bit 6 drives reference pin
// - Ladder bit 5 selects external rail pair
// - Reset clears ladder power and pin drive
// - Ladder setup unchanged by sleep and wake
// - Ladder works with no comparator enabled
// - Setup bit 7 enables its comparator
// - Edge select picks rise, fall, any, none
`timescale 1ns/10ps

module clrc_ctrl #(
  parameter int NCMP = 3
) (
  // Clock, reset, enable
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire logic                      ce_i,
  // Register port
  input  wire logic [3:0]                addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  // Power state
  input  wire logic                      sleep_i,
  output logic                           wake_o,
  // Analog comparator raw outputs, asynchronous
  input  wire logic [NCMP-1:0]           cmp_raw_i,
  // Analog controls
  output clrc_pkg::clrc_cmp_setup_type [NCMP-1:0] cmp_ctrl_o,
  output clrc_pkg::clrc_ladder_type      ladder_ctrl_o,
  output logic      [NCMP-1:0]           cmp_pin_o,
  // Interrupts
  output logic                           irq_o,
  output logic                           irq_high_o
);

  // Read port and register map are laid out for exactly three comparators
  if (NCMP != clrc_pkg::NUM_CMP) begin : g_ncmp_check
    $error("NCMP must be 3");
  end

  // ****************************************
  // State
  // ****************************************
  clrc_pkg::clrc_cmp_setup_type [NCMP-1:0] setup_q;
  clrc_pkg::clrc_ladder_type               ladder_q;
  logic [NCMP-1:0] sync1_q;
  logic [NCMP-1:0] sync2_q;
  logic [NCMP-1:0] out_q;
  logic [NCMP-1:0] out_d;
  logic [NCMP-1:0] flag_q;
  logic [NCMP-1:0] ien_q;
  logic [NCMP-1:0] prio_q;
  logic [NCMP-1:0] event_d;
  logic            prime_q;
  clrc_pkg::clrc_bus_type bus;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ****************************************
  // Setup registers
  // ****************************************
  // Sleep is deliberately not an input here: contents survive any wake
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < NCMP; i++) begin
        setup_q[i] <= clrc_pkg::RST_SETUP;
      end
      ladder_q <= clrc_pkg::RST_LADDER;
    end else if (ce_i && bus.wr) begin
      case (bus.addr)
        clrc_pkg::ADDR_CMP_SETUP1: setup_q[0] <= bus.wdata;
        clrc_pkg::ADDR_CMP_SETUP2: setup_q[1] <= bus.wdata;
        clrc_pkg::ADDR_CMP_SETUP3: setup_q[2] <= bus.wdata;
        clrc_pkg::ADDR_LADDER:     ladder_q   <= bus.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Comparator outputs
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce_i) begin
      sync1_q <= cmp_raw_i;
      sync2_q <= sync1_q;
    end
  end

  // Disabled comparator reads low; polarity applied after sync
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      out_d[i] = setup_q[i].comparator_on &
                 (sync2_q[i] ^ setup_q[i].output_invert);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_q <= '0;
    end else if (ce_i) begin
      out_q <= out_d;
    end
  end

  // Prime blocks a false edge in the first cycle after reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prime_q <= 1'b0;
    end else if (ce_i) begin
      prime_q <= 1'b1;
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      case (setup_q[i].edge_select)
        clrc_pkg::EDGE_RISE: event_d[i] = out_d[i] & ~out_q[i];
        clrc_pkg::EDGE_FALL: event_d[i] = ~out_d[i] & out_q[i];
        clrc_pkg::EDGE_ANY:  event_d[i] = out_d[i] ^ out_q[i];
        default:             event_d[i] = 1'b0;
      endcase
      event_d[i] = event_d[i] & prime_q;
    end
  end

  // ****************************************
  // Flags, enables, priorities
  // ****************************************
  // Flag clears by writing one; a same-cycle event wins over the clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flag_q <= '0;
    end else if (ce_i) begin
      if (bus.wr && bus.addr == clrc_pkg::ADDR_FLAGS) begin
        flag_q <= (flag_q & ~bus.wdata[NCMP-1:0]) | event_d;
      end else begin
        flag_q <= flag_q | event_d;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ien_q  <= '0;
      prio_q <= '0;
    end else if (ce_i && bus.wr) begin
      if (bus.addr == clrc_pkg::ADDR_IRQ_EN) begin
        ien_q <= bus.wdata[NCMP-1:0];
      end
      if (bus.addr == clrc_pkg::ADDR_PRIORITY) begin
        prio_q <= bus.wdata[NCMP-1:0];
      end
    end
  end

  // Interrupt and wake are combinational so they work with core asleep
  assign irq_o      = |(flag_q & ien_q);
  assign irq_high_o = |(flag_q & ien_q & prio_q);
  assign wake_o     = sleep_i & irq_o;

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          clrc_pkg::ADDR_FLAGS:      rdata_o <= {5'h00, flag_q};
          clrc_pkg::ADDR_IRQ_EN:     rdata_o <= {5'h00, ien_q};
          clrc_pkg::ADDR_PRIORITY:   rdata_o <= {5'h00, prio_q};
          clrc_pkg::ADDR_CMP_SETUP1: rdata_o <= setup_q[0];
          clrc_pkg::ADDR_CMP_SETUP2: rdata_o <= setup_q[1];
          clrc_pkg::ADDR_CMP_SETUP3: rdata_o <= setup_q[2];
          clrc_pkg::ADDR_LADDER:     rdata_o <= ladder_q;
          clrc_pkg::ADDR_OUTPUTS:    rdata_o <= {out_q, 5'h00};
          default:                   rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Analog controls
  // ****************************************
  // Ladder fields go straight to the analog side, no comparator gating
  assign ladder_ctrl_o = ladder_q;
  assign cmp_ctrl_o    = setup_q;

  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      cmp_pin_o[i] = out_q[i] & setup_q[i].comparator_pin_drive;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_off;
    @(posedge clock_i) srst_i |=> (setup_q == '0) && (ladder_q == '0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset not off");

  property p_ladder_reset;
    @(posedge clock_i) srst_i |=>
      !ladder_ctrl_o.ladder_power && !ladder_ctrl_o.ladder_pin_drive;
  endproperty
  a_ladder_reset: assert property (p_ladder_reset) else $error("ladder on");

  property p_setup_hold;
    @(posedge clock_i) disable iff (srst_i)
      !(wr_i && ce_i) |=> $stable(setup_q) && $stable(ladder_q);
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup moved");

  property p_ladder_write;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_LADDER
      |=> ladder_ctrl_o == $past(wdata_i);
  endproperty
  a_ladder_write: assert property (p_ladder_write) else $error("ladder wr");

  property p_no_edge_none;
    @(posedge clock_i) disable iff (srst_i)
      setup_q[0].edge_select == clrc_pkg::EDGE_NONE && !flag_q[0]
      && !(ce_i && wr_i) |=> !flag_q[0];
  endproperty
  a_no_edge_none: assert property (p_no_edge_none) else $error("flag set");

  sequence s_rise1;
    ce_i && prime_q && setup_q[1].edge_select == clrc_pkg::EDGE_RISE
    && out_d[1] && !out_q[1];
  endsequence
  property p_rise_flag;
    @(posedge clock_i) disable iff (srst_i) s_rise1 |=> flag_q[1];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise lost");

  property p_off_reads_low;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && !setup_q[1].comparator_on ##1 ce_i && $stable(setup_q)
      |=> !out_q[1];
  endproperty
  a_off_reads_low: assert property (p_off_reads_low) else $error("out hi");

  property p_wake;
    @(posedge clock_i) disable iff (srst_i)
      sleep_i && |(flag_q & ien_q) |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_read_zero;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && rd_i && addr_i == clrc_pkg::ADDR_OUTPUTS |=> rdata_o[4:0] == 5'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unimpl bits");

  // ****************************************
  // Edge, flag and freeze checks
  // ****************************************
  sequence s_fall2;
    ce_i && prime_q && setup_q[2].edge_select == clrc_pkg::EDGE_FALL
    && !out_d[2] && out_q[2];
  endsequence
  property p_fall_flag;
    @(posedge clock_i) disable iff (srst_i) s_fall2 |=> flag_q[2];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall lost");

  sequence s_any0;
    ce_i && prime_q && setup_q[0].edge_select == clrc_pkg::EDGE_ANY
    && (out_d[0] != out_q[0]);
  endsequence
  property p_any_flag;
    @(posedge clock_i) disable iff (srst_i) s_any0 |=> flag_q[0];
  endproperty
  a_any_flag: assert property (p_any_flag) else $error("change lost");

  // Two flops between the raw pin and any logic
  sequence s_ce_run;
    (ce_i && !srst_i) ##1 (ce_i && !srst_i);
  endsequence
  property p_two_flop;
    @(posedge clock_i) s_ce_run |=> sync2_q == $past(cmp_raw_i, 2);
  endproperty
  a_two_flop: assert property (p_two_flop) else $error("sync path");

  property p_prime;
    @(posedge clock_i) srst_i ##1 !srst_i |=> flag_q == '0;
  endproperty
  a_prime: assert property (p_prime) else $error("false edge");

  property p_flag_clear;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_FLAGS && event_d == '0
      |=> (flag_q & $past(wdata_i[NCMP-1:0])) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("no clear");

  property p_set_wins;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_FLAGS && event_d[0]
      |=> flag_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_ien_write;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_IRQ_EN
      |=> ien_q == $past(wdata_i[NCMP-1:0]);
  endproperty
  a_ien_write: assert property (p_ien_write) else $error("ien wr");

  property p_prio_write;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_PRIORITY
      |=> prio_q == $past(wdata_i[NCMP-1:0]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("prio wr");

  property p_setup_write;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_CMP_SETUP1
      |=> setup_q[0] == $past(wdata_i);
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup wr");

  // Status register is read only: a write there must touch nothing
  property p_outputs_ro;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && wr_i && addr_i == clrc_pkg::ADDR_OUTPUTS
      |=> $stable(setup_q) && $stable(ladder_q) && $stable(ien_q)
          && $stable(prio_q);
  endproperty
  a_outputs_ro: assert property (p_outputs_ro) else $error("ro moved");

  property p_read_once;
    @(posedge clock_i) disable iff (srst_i)
      ce_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_read_once: assert property (p_read_once) else $error("rdata held");

  property p_ce_freeze;
    @(posedge clock_i) disable iff (srst_i)
      !ce_i |=> $stable(setup_q) && $stable(ladder_q) && $stable(flag_q)
                && $stable(out_q) && $stable(rdata_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("not frozen");

  property p_irq_high;
    @(posedge clock_i) disable iff (srst_i) irq_high_o |-> irq_o;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("prio alone");

endmodule : clrc_ctrl

//--- verilog/clrc_pkg.sv
// Package: register map, field layout and types of the comparator/ladder block
package clrc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_FLAGS      = 4'h0;
  localparam logic [3:0] ADDR_IRQ_EN     = 4'h1;
  localparam logic [3:0] ADDR_PRIORITY   = 4'h2;
  localparam logic [3:0] ADDR_CMP_SETUP1 = 4'h3;
  localparam logic [3:0] ADDR_CMP_SETUP2 = 4'h4;
  localparam logic [3:0] ADDR_CMP_SETUP3 = 4'h5;
  localparam logic [3:0] ADDR_LADDER     = 4'h6;
  localparam logic [3:0] ADDR_OUTPUTS    = 4'h7;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_ON         = 7;
  localparam int BIT_PIN_DRIVE  = 6;
  localparam int BIT_INVERT     = 5;
  localparam int BIT_EDGE_HI    = 4;
  localparam int BIT_EDGE_LO    = 3;
  localparam int BIT_PLUS_SEL   = 2;
  localparam int BIT_MINUS_HI   = 1;
  localparam int BIT_MINUS_LO   = 0;
  localparam int BIT_LAD_POWER  = 7;
  localparam int BIT_LAD_PIN    = 6;
  localparam int BIT_LAD_SRC    = 5;
  localparam int BIT_CODE_HI    = 4;
  localparam int BIT_OUT_LO     = 5;
  localparam int NUM_CMP        = 3;
  localparam logic [7:0] RST_SETUP   = 8'h00;
  localparam logic [7:0] RST_LADDER  = 8'h00;
  localparam logic [7:0] RST_IRQ     = 8'h00;
  localparam logic [7:0] FLAG_MASK   = 8'h07;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY  = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       comparator_on;
    logic       comparator_pin_drive;
    logic       output_invert;
    logic [1:0] edge_select;
    logic       plus_input_select;
    logic [1:0] minus_input_select;
  } clrc_cmp_setup_type;

  typedef struct packed {
    logic       ladder_power;
    logic       ladder_pin_drive;
    logic       ladder_source_select;
    logic [4:0] ladder_code;
  } clrc_ladder_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } clrc_bus_type;

endpackage : clrc_pkg

//--- tb/tb.sv
// Self-checking testbench for the comparator and ladder control block
`timescale 1ns/10ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic                               clock_i;
  logic                               srst_i;
  logic                               ce_i;
  logic [3:0]                         addr_i;
  logic [7:0]                         wdata_i;
  logic                               wr_i;
  logic                               rd_i;
  logic [7:0]                         rdata_o;
  logic                               sleep_i;
  logic                               wake_o;
  logic [2:0]                         cmp_raw_i;
  clrc_pkg::clrc_cmp_setup_type [2:0] cmp_ctrl_o;
  clrc_pkg::clrc_ladder_type          ladder_ctrl_o;
  logic [2:0]                         cmp_pin_o;
  logic                               irq_o;
  logic                               irq_high_o;
  int                                 err_total;
  int                                 comparisons;
  int                                 cycles;
  int                                 seed;
  logic [7:0]                         exp_q[$];
  logic [7:0]                         sv[4];
  logic                               rd_seen;

  clrc_ctrl #(.NCMP(3)) u_dut (.clock_i(clock_i), .srst_i(srst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .wake_o(wake_o),
    .cmp_raw_i(cmp_raw_i), .cmp_ctrl_o(cmp_ctrl_o),
    .ladder_ctrl_o(ladder_ctrl_o), .cmp_pin_o(cmp_pin_o), .irq_o(irq_o),
    .irq_high_o(irq_high_o));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Expected data noted now, compared by the monitor one cycle on
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask : rd

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // ****************************************
  // Clock, monitor, timeout
  // ****************************************
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  always @(posedge clock_i) rd_seen <= rd_i & ~srst_i;
  always @(negedge clock_i) if (rd_seen) check(rdata_o, exp_q.pop_front());

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    {srst_i, addr_i, wdata_i, wr_i, rd_i, sleep_i, cmp_raw_i} = '0;
    {err_total, comparisons, cycles} = '0;
    rd_seen = 1'b0;
    ce_i = 1'b1;
    seed = 64;
    srst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    wr(clrc_pkg::ADDR_IRQ_EN, 8'hff);
    rd(clrc_pkg::ADDR_IRQ_EN, 8'h07);
    wr(clrc_pkg::ADDR_IRQ_EN, 8'h00);
    $display("test registers done");
    // Edge modes spread over all three comparators
    for (int m = 0; m < 4; m++) begin
      wr(clrc_pkg::ADDR_CMP_SETUP1 + 4'(m % 3), 8'h80 | 8'(m << 3));
      repeat (4) @(posedge clock_i);
      wr(clrc_pkg::ADDR_FLAGS, 8'h07);
      cmp_raw_i[m % 3] <= 1'b1;
      repeat (4) @(posedge clock_i);
      rd(clrc_pkg::ADDR_FLAGS, (m % 2) ? 8'(1 << (m % 3)) : 8'h00);
      wr(clrc_pkg::ADDR_FLAGS, 8'h07);
      cmp_raw_i[m % 3] <= 1'b0;
      repeat (4) @(posedge clock_i);
      rd(clrc_pkg::ADDR_FLAGS, (m > 1) ? 8'(1 << (m % 3)) : 8'h00);
      wr(clrc_pkg::ADDR_CMP_SETUP1 + 4'(m % 3), 8'h00);
    end
    $display("test edge modes done");
    // Interrupt raised asleep, masked, cleared
    wr(clrc_pkg::ADDR_CMP_SETUP1, 8'hd8);
    wr(clrc_pkg::ADDR_IRQ_EN, 8'h01);
    wr(clrc_pkg::ADDR_PRIORITY, 8'h01);
    repeat (4) @(posedge clock_i);
    wr(clrc_pkg::ADDR_FLAGS, 8'h07);
    sleep_i   <= 1'b1;
    cmp_raw_i <= 3'h1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    check({5'h0, wake_o, irq_high_o, irq_o}, 8'h07);
    check({5'h0, cmp_pin_o}, 8'h01);
    rd(clrc_pkg::ADDR_OUTPUTS, 8'h20);
    wr(clrc_pkg::ADDR_IRQ_EN, 8'h00);
    @(negedge clock_i);
    check({6'h0, wake_o, irq_o}, 8'h00);
    wr(clrc_pkg::ADDR_FLAGS, 8'h01);
    wr(clrc_pkg::ADDR_IRQ_EN, 8'h01);
    @(negedge clock_i);
    check({7'h0, irq_o}, 8'h00);
    $display("test interrupt done");
    // Setups survive sleep and wake with the inputs moving
    for (int i = 0; i < 4; i++) begin
      sv[i] = 8'($random(seed));
      wr(clrc_pkg::ADDR_CMP_SETUP1 + 4'(i), sv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      cmp_raw_i <= 3'($random(seed));
    end
    sleep_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd(clrc_pkg::ADDR_CMP_SETUP1 + 4'(i), sv[i]);
    rd(clrc_pkg::ADDR_LADDER, sv[3]);
    @(negedge clock_i);
    check(cmp_ctrl_o[2], sv[2]);
    $display("test sleep done");
    // Ladder alone, every code with random control bits
    for (int i = 0; i < 3; i++) wr(clrc_pkg::ADDR_CMP_SETUP1 + 4'(i), 8'h00);
    for (int i = 0; i < 32; i++) begin
      sv[0] = {3'($random(seed)), 5'(i)};
      wr(clrc_pkg::ADDR_LADDER, sv[0]);
      @(negedge clock_i);
      check(ladder_ctrl_o, sv[0]);
      rd(clrc_pkg::ADDR_LADDER, sv[0]);
    end
    $display("test ladder done");
    // Software powers everything down before sleep; nothing may wake
    wr(clrc_pkg::ADDR_LADDER, 8'h00);
    wr(clrc_pkg::ADDR_FLAGS, 8'h07);
    sleep_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    check({7'h0, wake_o}, 8'h00);
    sleep_i <= 1'b0;
    // Clock enable low must swallow a write
    wr(clrc_pkg::ADDR_LADDER, 8'h1f);
    @(posedge clock_i);
    ce_i    <= 1'b0;
    addr_i  <= clrc_pkg::ADDR_LADDER;
    wdata_i <= 8'h0a;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    ce_i    <= 1'b1;
    rd(clrc_pkg::ADDR_LADDER, 8'h1f);
    $display("test enable done");
    // Reset in mid-run returns all setups to off
    wr(clrc_pkg::ADDR_LADDER, 8'he5);
    wr(clrc_pkg::ADDR_CMP_SETUP2, 8'hff);
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    check(cmp_ctrl_o[1], 8'h00);
    check(ladder_ctrl_o, 8'h00);
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    $display("test reset done");
    repeat (3) @(posedge clock_i);
    results();
  end
endmodule : tb
